// >>> rtl/stop_clock_pkg.sv
// Constants and types shared by the CPU stop-clock and throttle control
package stop_clock_pkg;

   // ------------------------------------
   // Mailbox port decode
   // ------------------------------------
   localparam logic [15:0] CMD_PORT_ADDR    = 16'h00b2; // Command mailbox
   localparam logic [15:0] STATUS_PORT_ADDR = 16'h00b3; // Status mailbox
   localparam logic [7:0]  MAILBOX_RESET    = 8'h00;    // Mailbox reset value

   // ------------------------------------
   // Timing
   // ------------------------------------
   localparam int CLK_PERIOD_NS      = 10;    // ref_clk period
   localparam int CLK_START_US       = 1000;  // CPU clock warm-up, usec
   localparam int CLK_START_CYCLES   = CLK_START_US * 1000 / CLK_PERIOD_NS;
   localparam int RTC_EDGES_PER_TICK = 1;     // RTC periods per 32 usec tick
   localparam int THROTTLE_W         = 8;     // Throttle interval width
   localparam int THROTTLE_EXTRA     = 2;     // Extra counts per interval

   // ------------------------------------
   // Break event vector layout
   // ------------------------------------
   localparam int BRK_IRQ_LO  = 0;   // IRQ 15..3 and 1 in bits 13..0
   localparam int BRK_NUM_IRQ = 14;  // Count of interrupt request lines
   localparam int BRK_NMI     = 14;  // Non-maskable interrupt
   localparam int BRK_RING    = 15;  // Serial ring indicate
   localparam int BRK_SMI     = 16;  // System management interrupt
   localparam int BRK_INTR    = 17;  // CPU interrupt
   localparam int BRK_SUSPEND = 18;  // Suspend button
   localparam int BRK_LOWBAT  = 19;  // Low battery
   localparam int BRK_EXTERNAL_SMI_N  = 20;  // External SMI input
   localparam int BRK_W       = 21;  // Width of break vector

   // Stop-clock mode select encoding
   localparam logic MODE_STOP_GRANT = 1'b0; // CPU clock kept running
   localparam logic MODE_STOP_CLOCK = 1'b1; // CPU clock stopped

   // ------------------------------------
   // I/O access carrier
   // ------------------------------------
   typedef struct packed {
      logic        valid;    // One-cycle access strobe
      logic        write;    // 1 write, 0 read
      logic        from_pci; // 1 from PCI, 0 from expansion bus master
      logic [15:0] addr;     // I/O address
      logic [7:0]  wdata;    // Write data
   } io_req_t;

   // Software stop-clock sequence states
   typedef enum logic [2:0] {
      ST_IDLE,       // Request negated
      ST_GRANT_WAIT, // Waiting for stop-grant cycle ready
      ST_GRANT,      // Stop grant, clock running
      ST_PCI_WAIT,   // Waiting for PCI clock to stop
      ST_CLK_OFF,    // Host clock stopped
      ST_WARMUP      // Clock restarted, latency running
   } stop_state_t;

endpackage

// >>> rtl/rtc_tick_gen.sv
// Slow tick generator counting rising edges of the RTC clock
module rtc_tick_gen
   import stop_clock_pkg::*;
#(
   parameter int EDGES = RTC_EDGES_PER_TICK // RTC edges per tick
) (
   input  wire logic ref_clk,       // System clock
   input  wire logic rst,           // Synchronous reset, high
   input  wire logic rtc_slow_clock, // Slow RTC clock, sampled
   output logic      tick           // One-cycle tick pulse
);

   // ------------------------------------
   // Edge detection and division
   // ------------------------------------
   localparam int CW = (EDGES > 1) ? $clog2(EDGES) : 1;

   logic          rtc_q;   // Previous RTC level
   logic [CW-1:0] div_q;   // Edge count within a tick

   // Previous level for edge detection
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rtc_q <= 1'b0;
      end else begin
         rtc_q <= rtc_slow_clock;
      end
   end

   // Divide edges, tick on the last one
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_q <= '0;
         tick  <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (rtc_slow_clock && !rtc_q) begin
            if (div_q == CW'(EDGES - 1)) begin
               div_q <= '0;
               tick  <= 1'b1;
            end else begin
               div_q <= div_q + 1'b1;
            end
         end
      end
   end

endmodule

// >>> rtl/cpu_stop_clock_throttle.sv
// CPU stop-clock, throttle and mailbox port control
//
// Function
// R1: Two 8-bit read/write mailbox ports, B2h/B3h
// R2: Claim PCI I/O to B2h/B3h, return data
// R3: Expansion bus masters never reach mailboxes
// R4: Command write raises SMI when enabled
// R5: Callback routes event to PCI line A
// R6: Mailbox status flag set; handler clears it
// R7: Command read starts stop-clock when enabled
// R8: Host clock stops only after PCI clock
// R9: Request, CPU grant cycle, bridge returns ready
// R10: Stop CPU clock after grant ready
// R11: Restart clock, wait latency, then negate
// R12: Leave stop grant by negating request
// R13: Mode bit picks stop grant or clock
// R14: Enabled break events end software stop
// R15: Break sources: IRQs, NMI, ring, SMI, more
// R16: Ignore breaks until grant cycle completes
// R17: One shared timer times both throttle intervals
// R18: Load high/low time, toggle at zero
// R19: Break while negated reloads high time
// R20: 8-bit timer on 32 usec tick
// R21: Each period lasts two counts longer
// R22: PCI clock stoppable via clock-run
// R23: One shared stop-clock request output
module cpu_stop_clock_throttle
   import stop_clock_pkg::*;
#(
   parameter int START_CYCLES = CLK_START_CYCLES // CPU clock warm-up
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // I/O access to mailbox ports
   input  wire io_req_t               io_req,
   output logic                       io_claim,
   output logic [7:0]                 io_rdata,
   output logic                       io_rdata_valid,
   // Mailbox control and status
   input  wire logic                  mailbox_smi_enable,
   input  wire logic                  callback_enable,
   input  wire logic                  mailbox_status_clear,
   output logic                       mailbox_status_flag,
   output logic                       sys_mgmt_interrupt_n,
   output logic                       pci_interrupt_line_a,
   // Clock control settings
   input  wire logic                  sw_stop_enable,
   input  wire logic                  stop_clock_mode_select,
   input  wire logic                  pci_clk_ctrl_enable,
   input  wire logic                  throttle_enable,
   input  wire logic [THROTTLE_W-1:0] throttle_high_time,
   input  wire logic [THROTTLE_W-1:0] throttle_low_time,
   input  wire logic                  break_group_enable,
   input  wire logic [BRK_W-1:0]      break_enable,
   // Break event sources and RTC slow clock
   input  wire logic [BRK_NUM_IRQ-1:0] irq_lines,
   input  wire logic                  nmi,
   input  wire logic                  serial_ring_indicate_n,
   input  wire logic                  smi_event,
   input  wire logic                  cpu_intr,
   input  wire logic                  suspend_button_n,
   input  wire logic                  low_battery_n,
   input  wire logic                  external_smi_n,
   input  wire logic                  rtc_slow_clock,
   // CPU and host bridge handshake
   input  wire logic                  cpu_burst_ready_n,
   input  wire logic                  stop_grant_cycle,
   input  wire logic                  pci_clock_stopped,
   output logic                       stop_clock_request_n,
   output logic                       host_clock_out_en,
   output logic                       pci_clock_run_enable
);
   // ------------------------------------
   // Declarations
   // ------------------------------------
   localparam int WW = $clog2(START_CYCLES + 1); // Warm-up counter width
   logic [7:0]            cmd_q;        // Command mailbox
   logic [7:0]            status_q;     // Status mailbox
   logic                  route_cb_q;   // Event went to PCI line A
   stop_state_t           state_q;      // Software sequence state
   logic [WW-1:0]         warm_q;       // Warm-up countdown
   logic [THROTTLE_W:0]   thr_cnt_q;    // Shared throttle timer
   logic                  thr_req_q;    // Throttle request asserted
   logic                  tick;         // 32 usec tick
   logic [BRK_W-1:0]      brk_src;      // Break sources, active high
   logic                  brk_any;      // Enabled break present
   logic                  hit_cmd;      // Claimed command port access
   logic                  hit_sts;      // Claimed status port access
   logic                  sw_req;       // Software sequence requesting
   logic                  grant_done;   // Ready for stop grant seen
   // ------------------------------------
   // Mailbox decode
   // ------------------------------------
   // Only PCI accesses are claimed; expansion bus masters fall through
   // R3: PCI-only decode
   assign hit_cmd  = io_req.valid && io_req.from_pci
                     && (io_req.addr == CMD_PORT_ADDR);
   assign hit_sts  = io_req.valid && io_req.from_pci
                     && (io_req.addr == STATUS_PORT_ADDR);
   // R2: positive claim
   assign io_claim = hit_cmd || hit_sts;

   // Mailbox storage
   // R1: write stores value
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmd_q    <= MAILBOX_RESET;
         status_q <= MAILBOX_RESET;
      end else if (io_req.write) begin
         if (hit_cmd) begin
            cmd_q <= io_req.wdata;
         end
         if (hit_sts) begin
            status_q <= io_req.wdata;
         end
      end
   end

   // Read data from own registers, one cycle after the access
   // R2: internal read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         io_rdata       <= 8'h00;
         io_rdata_valid <= 1'b0;
      end else begin
         io_rdata_valid <= io_claim && !io_req.write;
         if (io_claim && !io_req.write) begin
            io_rdata <= hit_cmd ? cmd_q : status_q;
         end
      end
   end
   // ------------------------------------
   // Command write event
   // ------------------------------------
   // Flag stays until the handler clears it; a new event wins the clear
   // R6: status flag set
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mailbox_status_flag <= 1'b0;
         route_cb_q          <= 1'b0;
      end else if (hit_cmd && io_req.write && mailbox_smi_enable) begin
         mailbox_status_flag <= 1'b1;
         // R5: callback routing choice
         route_cb_q          <= callback_enable;
      end else if (mailbox_status_clear) begin
         mailbox_status_flag <= 1'b0;
      end
   end

   // Interrupt outputs follow the pending flag
   // R4: SMI while pending
   assign sys_mgmt_interrupt_n = !(mailbox_status_flag && !route_cb_q);
   // R5: callback on line A
   assign pci_interrupt_line_a = mailbox_status_flag && route_cb_q;
   // ------------------------------------
   // Break events
   // ------------------------------------
   // Pins are active low where named so; all become active high here
   // R15: break source set
   assign brk_src = {!external_smi_n, !low_battery_n, !suspend_button_n,
                     cpu_intr, smi_event, !serial_ring_indicate_n, nmi,
                     irq_lines};
   // R14: per-source and group enables
   assign brk_any = break_group_enable && |(brk_src & break_enable);
   // ------------------------------------
   // Software stop-clock sequence
   // ------------------------------------
   // R9: ready for the grant cycle completes the cycle
   assign grant_done = !cpu_burst_ready_n && stop_grant_cycle;

   // Sequence state; breaks count only once the grant cycle is done
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // R7: command read starts sequence
               if (hit_cmd && !io_req.write && sw_stop_enable) begin
                  state_q <= ST_GRANT_WAIT;
               end
            end
            ST_GRANT_WAIT: begin
               // R13: mode picks grant or clock stop
               // R8: no clock stop without PCI clock control
               if (grant_done) begin
                  if (stop_clock_mode_select == MODE_STOP_CLOCK
                      && pci_clk_ctrl_enable) begin
                     state_q <= ST_PCI_WAIT;
                  end else begin
                     state_q <= ST_GRANT;
                  end
               end
            end
            ST_GRANT: begin
               // R12: leave by negating request
               // R16: breaks counted only after grant
               if (brk_any) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_PCI_WAIT: begin
               // Host clock never stopped yet, so no warm-up needed
               if (brk_any) begin
                  state_q <= ST_IDLE;
               end else if (pci_clock_stopped) begin
                  // R10: clock off after grant ready
                  state_q <= ST_CLK_OFF;
               end
            end
            ST_CLK_OFF: begin
               // R14: break ends stop state
               if (brk_any) begin
                  state_q <= ST_WARMUP;
               end
            end
            ST_WARMUP: begin
               // R11: negate after latency
               if (warm_q == '0) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
   // Warm-up latency counter, loaded as the clock restarts
   // R11: clock start latency
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         warm_q <= '0;
      end else if (state_q == ST_CLK_OFF) begin
         warm_q <= WW'(START_CYCLES - 1);
      end else if (warm_q != '0) begin
         warm_q <= warm_q - 1'b1;
      end
   end

   assign sw_req = (state_q != ST_IDLE);
   // R8: host clock gated only in clock-off state
   assign host_clock_out_en    = (state_q != ST_CLK_OFF);
   // R22: clock-run allowed when PCI clock control on
   assign pci_clock_run_enable = pci_clk_ctrl_enable;
   // ------------------------------------
   // Clock throttle
   // ------------------------------------
   // R20: 32 usec tick from RTC clock
   rtc_tick_gen #(
      .EDGES (RTC_EDGES_PER_TICK)
   ) u_tick (
      .ref_clk        (ref_clk),
      .rst            (rst),
      .rtc_slow_clock (rtc_slow_clock),
      .tick           (tick)
   );
   // Loading value plus one and toggling on the tick at zero gives
   // a period of the programmed count plus two ticks
   // R17: one timer for both intervals
   // R21: two extra counts
   always_ff @(posedge ref_clk) begin
      if (rst || !throttle_enable) begin
         thr_cnt_q <= '0;
         thr_req_q <= 1'b0;
      end else if (!thr_req_q && brk_any) begin
         // R19: break postpones assertion
         thr_cnt_q <= {1'b0, throttle_high_time} + 1'b1;
      end else if (tick) begin
         if (thr_cnt_q == '0) begin
            // R18: toggle at zero, load other time
            thr_req_q <= !thr_req_q;
            thr_cnt_q <= {1'b0, thr_req_q ? throttle_high_time
                                          : throttle_low_time}
                         + (THROTTLE_W+1)'(THROTTLE_EXTRA - 1);
         end else begin
            thr_cnt_q <= thr_cnt_q - 1'b1;
         end
      end
   end
   // R23: one shared request output
   assign stop_clock_request_n = !(sw_req || thr_req_q);
   // ------------------------------------
   // Assertions
   // ------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   claim_decode_a: assert property ( // R2
      io_claim |-> io_req.from_pci && (io_req.addr[15:1] == 15'h0059))
      else $error("claim outside mailbox ports");
   ext_block_a: assert property ( // R3
      io_req.valid && !io_req.from_pci |-> !io_claim)
      else $error("expansion master claimed");
   mailbox_read_a: assert property ( // R1
      hit_cmd && io_req.write ##1 hit_cmd && !io_req.write
      |=> io_rdata_valid && io_rdata == $past(io_req.wdata, 2))
      else $error("command port read mismatch");
   smi_raise_a: assert property ( // R4
      hit_cmd && io_req.write && mailbox_smi_enable && !callback_enable
      |=> !sys_mgmt_interrupt_n && !pci_interrupt_line_a)
      else $error("SMI not raised");
   no_smi_a: assert property ( // R4
      !mailbox_status_flag && !(hit_cmd && io_req.write
                                && mailbox_smi_enable)
      |=> !mailbox_status_flag && sys_mgmt_interrupt_n)
      else $error("SMI without enabled write");
   callback_route_a: assert property ( // R5
      hit_cmd && io_req.write && mailbox_smi_enable && callback_enable
      |=> pci_interrupt_line_a && sys_mgmt_interrupt_n)
      else $error("callback not on line A");
   set_wins_a: assert property ( // R6
      hit_cmd && io_req.write && mailbox_smi_enable && mailbox_status_clear
      |=> mailbox_status_flag)
      else $error("event lost to clear");
   sw_start_a: assert property ( // R7
      state_q == ST_IDLE && hit_cmd && !io_req.write && sw_stop_enable
      |=> !stop_clock_request_n [*2])
      else $error("stop request not started");
   host_gate_a: assert property ( // R8
      !host_clock_out_en |-> pci_clk_ctrl_enable
                             && $past(pci_clock_stopped))
      else $error("host clock stopped early");
   warm_hold_a: assert property ( // R11
      state_q == ST_CLK_OFF && brk_any
      |=> host_clock_out_en && !stop_clock_request_n)
      else $error("request negated before warm-up");
   grant_exit_a: assert property ( // R12
      state_q == ST_GRANT && brk_any && !throttle_enable
      |=> stop_clock_request_n)
      else $error("stop grant not left");
   break_ignore_a: assert property ( // R16
      state_q == ST_GRANT_WAIT && !grant_done |=> state_q == ST_GRANT_WAIT)
      else $error("break taken before grant");
   throttle_toggle_a: assert property ( // R18
      throttle_enable && tick && thr_cnt_q == '0
      && !(!thr_req_q && brk_any) |=> thr_req_q != $past(thr_req_q))
      else $error("throttle did not toggle");
   throttle_reload_a: assert property ( // R19
      throttle_enable && !thr_req_q && brk_any
      |=> thr_cnt_q == {1'b0, $past(throttle_high_time)} + 9'h001)
      else $error("break did not reload");

endmodule

// >>> dv/cpu_bridge_model.sv
// CPU and host bridge model answering the stop-clock request
module cpu_bridge_model
   import stop_clock_pkg::*;
(
   input  wire logic ref_clk,              // System clock
   input  wire logic rst,                  // Synchronous reset, high
   input  wire logic stop_clock_request_n, // Request from the block
   input  wire logic pci_clock_run_enable, // PCI clock may be stopped
   input  wire logic grant_hold,           // Bench delays the grant cycle
   output logic      cpu_burst_ready_n,    // Ready to the CPU, low
   output logic      stop_grant_cycle,     // Current cycle is stop grant
   output logic      pci_clock_stopped     // PCI clock is stopped
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;  // Cycles since request seen
   logic       done_q; // Grant cycle already completed
   // ------------------------------------------
   // Grant cycle: an ordinary ready first, then the grant
   // ------------------------------------------
   // flush then grant
   always_ff @(posedge ref_clk) begin
      cpu_burst_ready_n <= 1'b1;
      stop_grant_cycle  <= 1'b0;
      if (rst || stop_clock_request_n) begin
         cnt_q  <= 4'h0;
         done_q <= 1'b0;
      end else if (!done_q && !grant_hold) begin
         cnt_q <= cnt_q + 4'h1;
         // Ordinary ready without grant must not count
         if (cnt_q == 4'h1) cpu_burst_ready_n <= 1'b0;
         if (cnt_q == 4'h3) begin
            cpu_burst_ready_n <= 1'b0;
            stop_grant_cycle  <= 1'b1;
            done_q            <= 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      pci_clock_stopped <= !rst && pci_clock_run_enable && done_q
                           && !stop_clock_request_n;
   end
endmodule

// >>> dv/cpu_stop_clock_throttle_test.sv
// Self-checking bench for the stop-clock and throttle block
module cpu_stop_clock_throttle_test
   import stop_clock_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int START = 20; // Shortened warm-up count
   logic ref_clk = 0, rst = 1, rtc_slow_clock = 0, grant_hold = 0;
   io_req_t io_req = '0;
   logic io_claim, io_rdata_valid, mailbox_status_flag, pci_interrupt_line_a;
   logic sys_mgmt_interrupt_n, stop_clock_request_n, host_clock_out_en;
   logic pci_clock_run_enable, cpu_burst_ready_n, stop_grant_cycle;
   logic pci_clock_stopped;
   logic [7:0] io_rdata;
   logic mailbox_smi_enable = 0, callback_enable = 0, mailbox_status_clear = 0;
   logic sw_stop_enable = 0, stop_clock_mode_select = 0, throttle_enable = 0;
   logic pci_clk_ctrl_enable = 0, break_group_enable = 0;
   logic [7:0] throttle_high_time = 8'h04, throttle_low_time = 8'h01;
   logic [BRK_W-1:0] break_enable = '0, ev = '0; // ev: active break sources
   wire [BRK_NUM_IRQ-1:0] irq_lines = ev[BRK_NUM_IRQ-1:0];
   wire nmi = ev[BRK_NMI], smi_event = ev[BRK_SMI], cpu_intr = ev[BRK_INTR];
   wire serial_ring_indicate_n = ~ev[BRK_RING];
   wire suspend_button_n = ~ev[BRK_SUSPEND], low_battery_n = ~ev[BRK_LOWBAT];
   wire external_smi_n = ~ev[BRK_EXTERNAL_SMI_N];
   int n_fail = 0, checks = 0, cyc = 0;
   logic [3:0] rtc_div = 4'h0; // RTC period is 20 clocks
   cpu_stop_clock_throttle #(.START_CYCLES(START)) cpu_stop_clock_throttle_inst (
      .ref_clk, .rst, .io_req, .io_claim, .io_rdata, .io_rdata_valid,
      .mailbox_smi_enable, .callback_enable, .mailbox_status_clear,
      .mailbox_status_flag, .sys_mgmt_interrupt_n, .pci_interrupt_line_a,
      .sw_stop_enable, .stop_clock_mode_select, .pci_clk_ctrl_enable,
      .throttle_enable, .throttle_high_time, .throttle_low_time,
      .break_group_enable, .break_enable, .irq_lines, .nmi,
      .serial_ring_indicate_n, .smi_event, .cpu_intr, .suspend_button_n,
      .low_battery_n, .external_smi_n, .rtc_slow_clock, .cpu_burst_ready_n,
      .stop_grant_cycle, .pci_clock_stopped, .stop_clock_request_n,
      .host_clock_out_en, .pci_clock_run_enable);
   cpu_bridge_model cpu_bridge_model_inst (.ref_clk, .rst,
      .stop_clock_request_n, .pci_clock_run_enable, .grant_hold,
      .cpu_burst_ready_n, .stop_grant_cycle, .pci_clock_stopped);
   // ------------------------------------------
   // Clocks, timeout, reporting
   // ------------------------------------------
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      rtc_div <= (rtc_div == 4'h9) ? 4'h0 : rtc_div + 4'h1;
      if (rtc_div == 4'h9) rtc_slow_clock <= ~rtc_slow_clock;
      cyc <= cyc + 1;
      // Hang guard, well past the expected run
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cb(string n, logic e, logic g);
      cmp(n, {7'h0, e}, {7'h0, g});
   endtask
   // Bounded wait for request (s=0) or host clock (s=1) level
   task automatic wait_for(bit s, logic lvl, int lim);
      for (int i = 0; i < lim && (s ? host_clock_out_en
                                  : stop_clock_request_n) !== lvl; i++)
         @(posedge ref_clk) #1;
   endtask
   // One I/O byte; claim, read strobe and data judged
   task automatic io(logic w, logic p, logic [15:0] a, logic [7:0] d,
                     logic [7:0] e = 8'h0);
      logic hit;
      hit = p && (a == CMD_PORT_ADDR || a == STATUS_PORT_ADDR);
      @(posedge ref_clk) io_req <= '{1'b1, w, p, a, d};
      #1 cb("io_claim", hit, io_claim);
      @(posedge ref_clk) io_req.valid <= 1'b0;
      #1 cb("rvalid", hit && !w, io_rdata_valid);
      if (hit && !w) cmp("io_rdata", e, io_rdata);
   endtask
   task automatic clear_flag();
      @(posedge ref_clk) mailbox_status_clear <= 1'b1;
      @(posedge ref_clk) mailbox_status_clear <= 1'b0;
      #1 cb("flag", 1'b0, mailbox_status_flag);
   endtask
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_mailbox();
      io(1, 1, CMD_PORT_ADDR, 8'h5a);
      io(1, 1, STATUS_PORT_ADDR, 8'ha5);
      io(1, 0, CMD_PORT_ADDR, 8'h11);
      io(1, 1, 16'h00b4, 8'h22);
      io(0, 1, CMD_PORT_ADDR, 8'h0, 8'h5a);
      io(0, 1, STATUS_PORT_ADDR, 8'h0, 8'ha5);
      io(0, 0, STATUS_PORT_ADDR, 8'h0, 8'h0);
      cb("flag", 1'b0, mailbox_status_flag);
      cb("req_n", 1'b1, stop_clock_request_n);
      @(posedge ref_clk) mailbox_smi_enable <= 1'b1;
      io(1, 1, STATUS_PORT_ADDR, 8'h01);
      cb("flag", 1'b0, mailbox_status_flag);
      io(1, 1, CMD_PORT_ADDR, 8'h02);
      cb("flag", 1'b1, mailbox_status_flag);
      cb("smi_n", 1'b0, sys_mgmt_interrupt_n);
      cb("line_a", 1'b0, pci_interrupt_line_a);
      clear_flag();
      cb("smi_n", 1'b1, sys_mgmt_interrupt_n);
      @(posedge ref_clk) callback_enable <= 1'b1;
      io(1, 1, CMD_PORT_ADDR, 8'h03);
      cb("line_a", 1'b1, pci_interrupt_line_a);
      cb("smi_n", 1'b1, sys_mgmt_interrupt_n);
      clear_flag();
   endtask
   // Stop grant ended by break source i
   task automatic t_grant(int i);
      @(posedge ref_clk) begin
         sw_stop_enable <= 1'b1;
         stop_clock_mode_select <= MODE_STOP_GRANT;
         break_group_enable <= 1'b1;
         break_enable <= BRK_W'(1) << i;
         grant_hold <= 1'b1;
      end
      io(0, 1, CMD_PORT_ADDR, 8'h0, 8'h03);
      cb("req_n", 1'b0, stop_clock_request_n);
      @(posedge ref_clk) ev <= BRK_W'(1) << i;
      repeat (4) @(posedge ref_clk);
      #1 cb("req_n", 1'b0, stop_clock_request_n);
      @(posedge ref_clk) begin
         break_group_enable <= 1'b0;
         grant_hold <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      #1 cb("req_n", 1'b0, stop_clock_request_n);
      cb("clk_en", 1'b1, host_clock_out_en);
      @(posedge ref_clk) break_group_enable <= 1'b1;
      wait_for(0, 1'b1, 10);
      cb("req_n", 1'b1, stop_clock_request_n);
      @(posedge ref_clk) ev <= '0;
   endtask
   task automatic t_clock(logic pce);
      int n;
      @(posedge ref_clk) begin
         stop_clock_mode_select <= MODE_STOP_CLOCK;
         pci_clk_ctrl_enable <= pce;
         break_enable <= BRK_W'(1) << BRK_NMI;
      end
      io(0, 1, CMD_PORT_ADDR, 8'h0, 8'h03);
      wait_for(1, 1'b0, 30);
      cb("clk_en", !pce, host_clock_out_en);
      if (pce) cb("pci_stopped", 1'b1, pci_clock_stopped);
      @(posedge ref_clk) ev[BRK_NMI] <= 1'b1;
      wait_for(1, 1'b1, 10);
      n = 0;
      while (stop_clock_request_n === 1'b0 && n < 100) begin
         @(posedge ref_clk) #1;
         n++;
      end
      cmp("warmup", pce ? 8'(START) : 8'h1, 8'(n));
      @(posedge ref_clk) ev <= '0;
   endtask
   // Count RTC rises while the request holds level lvl
   task automatic ticks(logic lvl, output int n);
      logic p;
      n = 0;
      p = rtc_slow_clock;
      for (int i = 0; i < 2000 && stop_clock_request_n === lvl; i++) begin
         @(posedge ref_clk) #1;
         if (rtc_slow_clock && !p) n++;
         p = rtc_slow_clock;
      end
   endtask
   task automatic t_throttle();
      int n;
      @(posedge ref_clk) begin
         sw_stop_enable <= 1'b0;
         throttle_enable <= 1'b1;
         break_enable <= BRK_W'(1) << BRK_INTR;
      end
      wait_for(0, 1'b0, 400);
      ticks(0, n);
      cmp("low_period", throttle_low_time + 8'h2, 8'(n));
      ticks(1, n);
      cmp("high_period", throttle_high_time + 8'h2, 8'(n));
      ticks(0, n);
      repeat (65) @(posedge ref_clk);
      ev[BRK_INTR] <= 1'b1;
      @(posedge ref_clk) ev[BRK_INTR] <= 1'b0;
      ticks(1, n);
      cb("reload", 1'b1, n >= 5);
      @(posedge ref_clk) throttle_enable <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_mailbox();
      for (int i = 0; i < BRK_W; i++) t_grant(i);
      t_clock(1'b1);
      t_clock(1'b0);
      t_throttle();
      close_out();
   end
endmodule
